// ### logic/dpso_protect.v
// Drive protection, stall prevention and selectable status outputs with a Wishbone slave
// Operation
// - Code 12 output active while run command present and output voltage generated.
// - Code 13 active while stopped; code 14 while at constant speed.
// - Code 11 active while frequency command is detected lost.
// - Code 16 active while healthy and waiting for a run command.
// - Code 17 follows the fault mask; mask 2 means any non-low-voltage trip.
// - Open-collector output and relay each pick one status item by selector.
// - Thermal enable 1 runs time-inverse heat model, trips on heat limit while above continuous level.
// - Thermal levels 50 to 150 percent, defaults 150/100; one-minute never below continuous.
// - Cooling type 0 derates cooling at low speed; 1 cooling is constant.
// - Warning level 30 to 150 percent default 150; time 0 to 30 s default 10.
// - Open-collector selector 5 shows the overload warning.
// - Overload trip after level exceeded for trip time; 30-200 percent, 0-60 s.
// - Accelerating: hold ramp while current above stall level, if enabled.
// - Constant speed: lower frequency while current above stall level, if enabled.
// - Decelerating: hold ramp while DC link above overvoltage threshold, if enabled.
// - Stall level 30 to 150 percent of rated current, default 150.
// - Stall mask three bits default 3: accel, constant, decel.
// - Code 7 output active while stall prevention acts.
// - Ramp time may stretch while stall prevention holds the ramp.
// - Phase-loss enable 1 trips output on U, V or W phase loss.
// - Input function 18 is normally-open trip, 19 normally-closed; range 0 to 24.
// - Normally-open trip input on causes fault and output cut-off.
// - Normally-closed trip input off causes fault and output cut-off.
`timescale 1ns/1ns
`default_nettype none
`include "dpso_regs.vh"
module dpso_protect #(
  parameter SEC_CYCLES = `DPSO_SEC_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  input wire [7:0] motor_current_i,
  input wire [7:0] speed_pct_i,
  input wire [1:0] drive_phase_i,
  input wire run_cmd_i,
  input wire output_active_i,
  input wire dc_over_i,
  input wire low_volt_trip_i,
  input wire freq_cmd_lost_i,
  input wire [2:0] phase_loss_i,
  input wire digital_input_4_i,
  input wire digital_input_5_i,
  output reg output_cutoff_o,
  output reg accel_hold_o,
  output reg decel_hold_o,
  output reg freq_reduce_o,
  output reg open_collector_output_o,
  output reg fault_relay_output_o
);
  localparam PH_STOP = 2'h0;
  localparam PH_ACC = 2'h1;
  localparam PH_CONST = 2'h2;
  localparam PH_DEC = 2'h3;

  reg [31:0] ctrl_q;
  reg [31:0] therm_q;
  reg [31:0] oload_q;
  reg [31:0] trip_q;
  reg [31:0] stall_q;
  reg [31:0] outsel_q;
  reg [31:0] rated_q;
  reg [3:0] fault_q;
  reg [47:0] heat_q;
  reg [31:0] dat_d;
  wire [31:0] wval;
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;

  wire thermal_protect_enable = ctrl_q[0];
  wire overload_trip_enable = ctrl_q[1];
  wire phase_loss_protect_enable = ctrl_q[2];
  wire motor_cooling_type = ctrl_q[3];
  wire fault_reset = ctrl_q[4];
  wire [7:0] input4_function = ctrl_q[15:8];
  wire [7:0] input5_function = ctrl_q[23:16];
  wire [7:0] thermal_level_one_minute = therm_q[7:0];
  wire [7:0] thermal_level_continuous = therm_q[15:8];
  wire [7:0] overload_warn_level = oload_q[7:0];
  wire [7:0] overload_warn_time = oload_q[15:8];
  wire [7:0] overload_trip_level = trip_q[7:0];
  wire [7:0] overload_trip_time = trip_q[15:8];
  wire [7:0] stall_current_level = stall_q[7:0];
  wire [2:0] stall_enable_mask = stall_q[10:8];
  wire [4:0] open_collector_out_select = outsel_q[4:0];
  wire [4:0] relay_out_select = outsel_q[12:8];
  wire [2:0] fault_output_mask = outsel_q[18:16];
  wire [7:0] motor_rated_current = rated_q[7:0];

  // Pin inputs double-synchronised
  wire [7:0] pins_raw = {digital_input_5_i, digital_input_4_i, phase_loss_i, dc_over_i,
                         low_volt_trip_i, freq_cmd_lost_i};
  always @(posedge clk_i) begin
    if (rst_i) begin
      sync1_q <= 8'h00;
      sync2_q <= 8'h00;
    end else begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
    end
  end
  wire cmd_lost_s = sync2_q[0];
  wire lv_trip_s = sync2_q[1];
  wire dc_over_s = sync2_q[2];
  wire [2:0] ploss_s = sync2_q[5:3];
  wire in4_s = sync2_q[6];
  wire in5_s = sync2_q[7];

  // Current as percent of motor rated current
  wire [15:0] lvl_base = {8'h00, motor_rated_current};
  wire [15:0] cur_x100 = {8'h00, motor_current_i} * 16'h0064;
  wire above_warn = cur_x100 > overload_warn_level * lvl_base;
  wire above_trip = cur_x100 > overload_trip_level * lvl_base;
  wire above_stall = cur_x100 > stall_current_level * lvl_base;
  wire above_cont = cur_x100 > thermal_level_continuous * lvl_base;
  wire above_1min = cur_x100 > thermal_level_one_minute * lvl_base;

  // Clamp a value into a range
  function [7:0] clamp;
    input [7:0] v;
    input [7:0] lo;
    input [7:0] hi;
    begin
      clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
    end
  endfunction

  // Overload warning and trip timers
  wire warn_done;
  wire trip_done;
  dpso_timer #(.SEC_CYCLES(SEC_CYCLES)) u_warn (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(above_warn),
    .secs_i(overload_warn_time),
    .done_o(warn_done)
  );
  dpso_timer #(.SEC_CYCLES(SEC_CYCLES)) u_trip (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cond_i(overload_trip_enable && above_trip),
    .secs_i(overload_trip_time),
    .done_o(trip_done)
  );

  // Thermal model: heat grows by excess over cooling level (continuous, halved at low speed with type 0), sheds when below
  wire low_speed = (speed_pct_i < `DPSO_LOW_SPEED) && !motor_cooling_type;
  // Wide heat store so the default tick rate cannot wrap the limit
  wire [47:0] heat_limit = {40'h00_0000_0000, thermal_level_one_minute - thermal_level_continuous}
                           * SEC_CYCLES * `DPSO_THERM_SCALE;
  wire [7:0] cool_lvl = low_speed ? {1'b0, thermal_level_continuous[7:1]} : thermal_level_continuous;
  wire above_cool = cur_x100 > cool_lvl * lvl_base;
  wire [31:0] excess = {16'h0000, cur_x100 - (cool_lvl * lvl_base)} / {16'h0000, lvl_base | 16'h0001};
  always @(posedge clk_i) begin
    if (rst_i || !thermal_protect_enable) begin
      heat_q <= 48'h0000_0000_0000;
    end else if (above_1min || above_cool) begin
      heat_q <= heat_q + {16'h0000, excess} + 48'h0000_0000_0001;
    end else if (heat_q != 48'h0000_0000_0000) begin
      heat_q <= heat_q - 48'h0000_0000_0001;
    end
  end
  wire therm_trip = thermal_protect_enable && above_cont && (heat_q >= heat_limit);

  // External trip inputs by function code
  wire [1:0] in_s = {in5_s, in4_s};
  wire [15:0] in_fn = {input5_function, input4_function};
  wire [1:0] ext_hit;
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : g_ext
      assign ext_hit[k] = (in_fn[k*8 +: 8] == `DPSO_FN_EXT_NO && in_s[k]) ||
                          (in_fn[k*8 +: 8] == `DPSO_FN_EXT_NC && !in_s[k]);
    end
  endgenerate
  wire ext4 = ext_hit[0];
  wire ext5 = ext_hit[1];
  wire ploss_trip = phase_loss_protect_enable && (ploss_s != 3'h0);
  wire other_trip = therm_trip || (overload_trip_enable && trip_done) || ploss_trip || ext4 || ext5;

  // Fault latch: bit0 low voltage, bit1 other trip; set wins over reset
  always @(posedge clk_i) begin
    if (rst_i) begin
      fault_q <= 4'h0;
    end else begin
      fault_q[0] <= lv_trip_s | (fault_q[0] & ~fault_reset);
      fault_q[1] <= other_trip | (fault_q[1] & ~fault_reset);
      fault_q[3:2] <= {ext5 | ext4, ploss_trip};
    end
  end
  wire tripped = fault_q[0] | fault_q[1];

  // Stall prevention by drive phase
  wire [5:0] st_phase = {PH_DEC, PH_CONST, PH_ACC};
  wire [2:0] st_cond = {dc_over_s, above_stall, above_stall};
  wire [2:0] st_hit;
  genvar s;
  generate
    for (s = 0; s < 3; s = s + 1) begin : g_stall
      // Mask bit s guards one drive phase
      assign st_hit[s] = stall_enable_mask[s] && (drive_phase_i == st_phase[s*2 +: 2]) && st_cond[s];
    end
  endgenerate
  wire st_acc = st_hit[0];
  wire st_con = st_hit[1];
  wire st_dec = st_hit[2];
  wire stalling = st_acc | st_con | st_dec;

  // Status item selection
  wire running = run_cmd_i && output_active_i && !tripped;
  function item;
    input [4:0] code;
    begin
      case (code)
        `DPSO_CODE_OL: item = warn_done;
        `DPSO_CODE_STALL: item = stalling;
        `DPSO_CODE_LOSS: item = cmd_lost_s;
        `DPSO_CODE_RUN: item = running;
        `DPSO_CODE_STOP: item = !output_active_i || drive_phase_i == PH_STOP;
        `DPSO_CODE_CONST: item = running && drive_phase_i == PH_CONST;
        `DPSO_CODE_WAIT: item = !tripped && !run_cmd_i;
        // Mask bit 2 has no effect here
        `DPSO_CODE_FAULT: item = (fault_output_mask[`DPSO_MASK_LV] && fault_q[0]) ||
                                 (fault_output_mask[`DPSO_MASK_OTHER] && fault_q[1]);
        default: item = 1'b0;
      endcase
    end
  endfunction

  // Trip and stall outputs, selected status items
  always @(posedge clk_i) begin
    if (rst_i) begin
      output_cutoff_o <= 1'b0;
      accel_hold_o <= 1'b0;
      decel_hold_o <= 1'b0;
      freq_reduce_o <= 1'b0;
      open_collector_output_o <= 1'b0;
      fault_relay_output_o <= 1'b0;
    end else begin
      output_cutoff_o <= tripped;
      accel_hold_o <= st_acc && !tripped;
      decel_hold_o <= st_dec && !tripped;
      freq_reduce_o <= st_con && !tripped;
      open_collector_output_o <= item(open_collector_out_select);
      fault_relay_output_o <= item(relay_out_select);
    end
  end

  // Wishbone classic slave
  wire req = cyc_i && stb_i && !ack_o;
  // Unselected byte lanes write as zero
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign wval[g*8 +: 8] = sel_i[g] ? dat_i[g*8 +: 8] : 8'h00;
    end
  endgenerate

  // Read data selection
  always @* begin
    case (adr_i)
      `DPSO_ADR_CTRL: dat_d = ctrl_q;
      `DPSO_ADR_THERM: dat_d = therm_q;
      `DPSO_ADR_OLOAD: dat_d = oload_q;
      `DPSO_ADR_TRIP: dat_d = trip_q;
      `DPSO_ADR_STALL: dat_d = stall_q;
      `DPSO_ADR_OUTSEL: dat_d = outsel_q;
      `DPSO_ADR_STATUS: dat_d = {24'h000000, stalling, warn_done, cmd_lost_s, running,
                                 open_collector_output_o, fault_relay_output_o, output_cutoff_o, 1'b0};
      `DPSO_ADR_FAULT: dat_d = {28'h0000000, fault_q};
      `DPSO_ADR_RATED: dat_d = rated_q;
      default: dat_d = 32'h0000_0000;
    endcase
  end

  // Register writes, levels clamped into range
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
      ctrl_q <= {8'h00, `DPSO_INSEL_RESET, 8'h00};
      therm_q <= `DPSO_THERM_RESET;
      oload_q <= `DPSO_OLOAD_RESET;
      trip_q <= `DPSO_TRIP_RESET;
      stall_q <= `DPSO_STALL_RESET;
      outsel_q <= `DPSO_OUTSEL_RESET;
      rated_q <= `DPSO_RATED_RESET;
    end else begin
      ack_o <= req;
      dat_o <= req ? dat_d : 32'h0000_0000;
      ctrl_q[4] <= 1'b0;
      if (req && we_i) begin
        case (adr_i)
          `DPSO_ADR_CTRL: begin
            ctrl_q[4:0] <= wval[4:0];
            ctrl_q[15:8] <= (wval[15:8] > `DPSO_MAX_INFN) ? ctrl_q[15:8] : wval[15:8];
            ctrl_q[23:16] <= (wval[23:16] > `DPSO_MAX_INFN) ? ctrl_q[23:16] : wval[23:16];
          end
          `DPSO_ADR_THERM: begin
            // One-minute level raised to continuous level if below it
            therm_q[15:8] <= clamp(wval[15:8], `DPSO_MIN_THERM, `DPSO_MAX_THERM);
            therm_q[7:0] <= (clamp(wval[7:0], `DPSO_MIN_THERM, `DPSO_MAX_THERM) <
                             clamp(wval[15:8], `DPSO_MIN_THERM, `DPSO_MAX_THERM)) ?
                            clamp(wval[15:8], `DPSO_MIN_THERM, `DPSO_MAX_THERM) :
                            clamp(wval[7:0], `DPSO_MIN_THERM, `DPSO_MAX_THERM);
          end
          `DPSO_ADR_OLOAD: begin
            oload_q[7:0] <= clamp(wval[7:0], `DPSO_MIN_WARN, `DPSO_MAX_WARN);
            oload_q[15:8] <= clamp(wval[15:8], 8'h00, `DPSO_MAX_WTIME);
          end
          `DPSO_ADR_TRIP: begin
            trip_q[7:0] <= clamp(wval[7:0], `DPSO_MIN_WARN, `DPSO_MAX_TRIPL);
            trip_q[15:8] <= clamp(wval[15:8], 8'h00, `DPSO_MAX_TTIME);
          end
          `DPSO_ADR_STALL: begin
            stall_q[7:0] <= clamp(wval[7:0], `DPSO_MIN_WARN, `DPSO_MAX_WARN);
            stall_q[10:8] <= wval[10:8];
          end
          `DPSO_ADR_OUTSEL: begin
            outsel_q[4:0] <= wval[4:0];
            outsel_q[12:8] <= wval[12:8];
            outsel_q[18:16] <= wval[18:16];
          end
          `DPSO_ADR_RATED: rated_q[7:0] <= wval[7:0];
          default: ;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### logic/dpso_regs.vh
// Register offsets, field layouts, reset values and timing counts of the drive protection block
`ifndef DPSO_REGS_VH
`define DPSO_REGS_VH
`define DPSO_ADR_CTRL 8'h00
`define DPSO_ADR_THERM 8'h04
`define DPSO_ADR_OLOAD 8'h08
`define DPSO_ADR_TRIP 8'h0C
`define DPSO_ADR_STALL 8'h10
`define DPSO_ADR_OUTSEL 8'h14
`define DPSO_ADR_STATUS 8'h18
`define DPSO_ADR_FAULT 8'h1C
`define DPSO_ADR_RATED 8'h20
`define DPSO_CTRL_RESET 32'h0000_0000
`define DPSO_THERM_RESET 32'h0000_6496
`define DPSO_OLOAD_RESET 32'h0000_0A96
`define DPSO_TRIP_RESET 32'h0000_3CB4
`define DPSO_STALL_RESET 32'h0000_0396
`define DPSO_OUTSEL_RESET 32'h0002_110C
`define DPSO_RATED_RESET 32'h0000_0064
`define DPSO_INSEL_RESET 16'h0403
`define DPSO_MIN_THERM 8'h32
`define DPSO_MAX_THERM 8'h96
`define DPSO_MIN_WARN 8'h1E
`define DPSO_MAX_WARN 8'h96
`define DPSO_MAX_TRIPL 8'hC8
`define DPSO_MAX_WTIME 8'h1E
`define DPSO_MAX_TTIME 8'h3C
`define DPSO_MAX_INFN 8'h18
`define DPSO_LOW_SPEED 8'h32
`define DPSO_FN_EXT_NO 8'h12
`define DPSO_FN_EXT_NC 8'h13
`define DPSO_CODE_OL 5'h05
`define DPSO_CODE_STALL 5'h07
`define DPSO_CODE_LOSS 5'h0B
`define DPSO_CODE_RUN 5'h0C
`define DPSO_CODE_STOP 5'h0D
`define DPSO_CODE_CONST 5'h0E
`define DPSO_CODE_WAIT 5'h10
`define DPSO_CODE_FAULT 5'h11
`define DPSO_MASK_LV 0
`define DPSO_MASK_OTHER 1
`define DPSO_SEC_NS 1000000000
`define DPSO_CLK_NS 10
`define DPSO_SEC_CYCLES (`DPSO_SEC_NS / `DPSO_CLK_NS)
`define DPSO_THERM_SCALE 60
`endif

// ### logic/dpso_timer.v
// Seconds-based qualification timer: fires after a condition holds for the set time
`timescale 1ns/1ns
`default_nettype none
`include "dpso_regs.vh"
module dpso_timer #(
  parameter SEC_CYCLES = `DPSO_SEC_CYCLES
) (
  input wire clk_i,
  input wire rst_i,
  input wire cond_i,
  input wire [7:0] secs_i,
  output reg done_o
);
  reg [31:0] tick_q;
  reg [7:0] secs_q;
  always @(posedge clk_i) begin
    if (rst_i || !cond_i) begin
      tick_q <= 32'h0000_0000;
      secs_q <= 8'h00;
      done_o <= 1'b0;
    end else if (secs_q >= secs_i) begin
      done_o <= 1'b1;
    end else if (tick_q >= SEC_CYCLES - 1) begin
      tick_q <= 32'h0000_0000;
      secs_q <= secs_q + 8'h01;
    end else begin
      tick_q <= tick_q + 32'h0000_0001;
    end
  end
endmodule
`default_nettype wire

// ### tb/dpso_protect_chk.sv
// Assertion checker bound to the drive protection block
`timescale 1ns/1ns
`default_nettype none
`include "dpso_regs.vh"
module dpso_protect_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic [1:0] drive_phase_i,
  input wire logic output_cutoff_o,
  input wire logic accel_hold_o,
  input wire logic decel_hold_o,
  input wire logic freq_reduce_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [2:0] since_q;
  // Cycles since a fault reset write was taken
  always_ff @(posedge clk_i)
    if (rst_i || (cyc_i && stb_i && we_i && !ack_o && adr_i == `DPSO_ADR_CTRL && sel_i[0] && dat_i[4]))
      since_q <= 3'h0;
    else if (since_q != 3'h7)
      since_q <= since_q + 3'h1;
  a_ack_one_cycle: assert property (ack_o |=> !ack_o) else $error("ack longer than one cycle");
  a_ack_follows_req: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request not answered");
  a_idle_data_zero: assert property (!ack_o |-> dat_o == 32'h0) else $error("read data not zero when idle");
  a_accel_in_phase: assert property (accel_hold_o |-> $past(drive_phase_i) == 2'h1) else $error("accel hold");
  a_reduce_in_phase: assert property (freq_reduce_o |-> $past(drive_phase_i) == 2'h2) else $error("reduce");
  a_decel_in_phase: assert property (decel_hold_o |-> $past(drive_phase_i) == 2'h3) else $error("decel hold");
  a_one_action: assert property ($onehot0({accel_hold_o, freq_reduce_o, decel_hold_o})) else $error("actions");
  a_cut_latched: assert property ($fell(output_cutoff_o) |-> since_q < 3'h6) else $error("cutoff dropped");
  c_fault_clear: cover property ($fell(output_cutoff_o));
  c_accel: cover property (accel_hold_o);
  c_decel: cover property (decel_hold_o);
endmodule
bind dpso_protect dpso_protect_chk u_chk (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .drive_phase_i, .output_cutoff_o, .accel_hold_o, .decel_hold_o, .freq_reduce_o);
`default_nettype wire

// ### tb/dpso_protect_tb.sv
// Self-checking testbench for the drive protection block
`timescale 1ns/1ns
`default_nettype none
module dpso_protect_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, run = 1'b0, act = 1'b0, dcov = 1'b0, lv = 1'b0, lost = 1'b0;
  logic tno = 1'b0, tnc = 1'b0, slow = 1'b0, hot;
  logic ack_o, cut, acc, dec, frq, oc, rly, in4, in5;
  logic [7:0] adr_i = 8'h00, cur = 8'h00;
  logic [3:0] sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd, lfsr = 32'h9061C51B;
  logic [1:0] ph = 2'h0;
  logic [2:0] pl = 3'h0, e;
  logic [10:0] t;
  int mismatches = 0, checks_done = 0;
  // Code, run, active, phase, lost, expected
  logic [10:0] stt [8] = '{11'h339, 11'h328, 11'h341, 11'h3B9, 11'h3B4, 11'h2C3, 11'h401, 11'h438};
  logic [31:0] rst_tbl [8] = '{32'h00040300, {16'h0, 8'd100, 8'd150}, {16'h0, 8'd10, 8'd150},
    {16'h0, 8'd60, 8'd180}, {21'h0, 3'd3, 8'd150}, {13'h0, 3'd2, 3'h0, 5'd17, 3'h0, 5'd12}, 32'h64, 32'h0};
  always #5 clk_i = ~clk_i;
  dpso_seq seq (.clk_i, .rst_i, .trip_no_i(tno), .trip_nc_i(tnc), .slow_i(slow), .contact_no_o(in4),
    .contact_nc_o(in5));
  dpso_protect #(.SEC_CYCLES(10)) uut (.clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .motor_current_i(cur), .speed_pct_i(lfsr[7:0]), .drive_phase_i(ph), .run_cmd_i(run),
    .output_active_i(act), .dc_over_i(dcov), .low_volt_trip_i(lv), .freq_cmd_lost_i(lost), .phase_loss_i(pl),
    .digital_input_4_i(in4), .digital_input_5_i(in5), .output_cutoff_o(cut), .accel_hold_o(acc),
    .decel_hold_o(dec), .freq_reduce_o(frq), .open_collector_output_o(oc), .fault_relay_output_o(rly));
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    if (ack_o !== 1'b1) begin
      mismatches++;
      complete_run();
    end
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wait_hi(input logic use_oc, input int lim);
    int n;
    n = 0;
    while ((use_oc ? oc : cut) !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk(use_oc ? oc : cut, 1'b1);
  endtask
  task automatic clear(input logic [31:0] c);
    // Let synchronised trip inputs settle so the reset is not overridden
    repeat (4) @(posedge clk_i);
    bus(1'b1, 8'h00, c | 32'h10);
    repeat (4) @(posedge clk_i);
    chk(cut, 1'b0);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, (i < 6) ? 8'(i * 4) : 8'(i * 4 + 8), 32'h0);
      chk(rd, rst_tbl[i]);
    end
    bus(1'b1, 8'h00, 32'h00191200);
    bus(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h00041200);
    bus(1'b1, 8'h04, 32'h0000783C);
    bus(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h00007878);
    bus(1'b1, 8'h10, 32'h00000314);
    bus(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0000031E);
    for (int i = 0; i < 8; i++) begin
      t = stt[i];
      bus(1'b1, 8'h14, {13'h0, 3'h2, 3'h0, t[10:6], 3'h0, t[10:6]});
      run <= t[5];
      act <= t[4];
      ph <= t[3:2];
      lost <= t[1];
      repeat (6) @(posedge clk_i);
      chk({oc, rly}, {2{t[0]}});
    end
    run <= 1'b1;
    act <= 1'b1;
    lost <= 1'b0;
    bus(1'b1, 8'h14, 32'h00020707);
    for (int m = 0; m < 8; m++) begin
      bus(1'b1, 8'h10, {21'h0, m[2:0], 8'd150});
      for (int p = 1; p < 4; p++) begin
        lfsr <= nxt(lfsr);
        cur <= (p == 1) ? 8'd151 : (m == 2 && p == 2) ? 8'd150 : lfsr[7:0];
        dcov <= lfsr[8];
        ph <= p[1:0];
        repeat (6) @(posedge clk_i);
        hot = cur > 8'd150;
        e = {p == 3 && m[2] && dcov, p == 2 && m[1] && hot, p == 1 && m[0] && hot};
        chk({dec, frq, acc}, e);
        chk(oc, |e);
      end
    end
    ph <= 2'h2;
    dcov <= 1'b0;
    cur <= 8'h00;
    bus(1'b1, 8'h14, 32'h00021105);
    bus(1'b1, 8'h08, 32'h00000196);
    cur <= 8'd200;
    repeat (4) @(posedge clk_i);
    chk(oc, 1'b0);
    wait_hi(1'b1, 40);
    bus(1'b1, 8'h0C, 32'h000002B4);
    bus(1'b1, 8'h00, 32'h00131202);
    repeat (8) @(posedge clk_i);
    chk(cut, 1'b0);
    wait_hi(1'b0, 60);
    cur <= 8'h00;
    clear(32'h00131200);
    tno <= 1'b1;
    wait_hi(1'b0, 30);
    chk(rly, 1'b1);
    bus(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0000000A);
    bus(1'b0, 8'h18, 32'h0);
    chk(rd, 32'h00000006);
    tno <= 1'b0;
    repeat (8) @(posedge clk_i);
    chk(cut, 1'b1);
    clear(32'h00131200);
    slow <= 1'b1;
    tnc <= 1'b1;
    wait_hi(1'b0, 40);
    tnc <= 1'b0;
    clear(32'h00131200);
    pl <= 3'h2;
    repeat (8) @(posedge clk_i);
    chk(cut, 1'b0);
    bus(1'b1, 8'h00, 32'h00131204);
    wait_hi(1'b0, 30);
    pl <= 3'h0;
    clear(32'h00131204);
    lv <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(rly, 1'b0);
    bus(1'b1, 8'h14, 32'h0001110C);
    repeat (4) @(posedge clk_i);
    chk(rly, 1'b1);
    lv <= 1'b0;
    clear(32'h00131200);
    // Thermal model: shaft cooling at low speed, then separate fan
    lfsr <= 32'h9061C510;
    bus(1'b1, 8'h04, 32'h00006496);
    cur <= 8'd110;
    bus(1'b1, 8'h00, 32'h00131201);
    repeat (300) @(posedge clk_i);
    chk(cut, 1'b0);
    wait_hi(1'b0, 400);
    clear(32'h00131200);
    bus(1'b1, 8'h00, 32'h00131209);
    repeat (700) @(posedge clk_i);
    chk(cut, 1'b0);
    cur <= 8'd200;
    wait_hi(1'b0, 400);
    cur <= 8'h00;
    clear(32'h00131200);
    complete_run();
  end
  initial begin
    repeat (100000) @(posedge clk_i);
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire

// ### tb/dpso_seq.sv
// External control sequence model driving the trip contacts
`timescale 1ns/1ns
`default_nettype none
module dpso_seq (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic trip_no_i,
  input wire logic trip_nc_i,
  input wire logic slow_i,
  output logic contact_no_o,
  output logic contact_nc_o
);
  logic [3:0] dly_q;
  logic go;
  assign go = !slow_i || dly_q > 4'h3;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dly_q <= 4'h0;
      contact_no_o <= 1'b0;
      contact_nc_o <= 1'b1;
    end else begin
      dly_q <= (trip_no_i || trip_nc_i) ? dly_q + {3'h0, dly_q != 4'hF} : 4'h0;
      contact_no_o <= trip_no_i && go;
      contact_nc_o <= !(trip_nc_i && go);
    end
  end
endmodule
`default_nettype wire
